/* File: rtl/fwsr_poller.sv */
// host-side poller for flash program/erase status
`timescale 1ns/1ps
// Function
// (RL1) device shows inverted bit 7 while programming, true value when done.
// (RL2) bit 7 polling status valid after last write strobe of sequence.
// (RL3) host reads status at the address being programmed.
// (RL4) protected program target: polling shows about 1 us then array data.
// (RL5) erase drives bit 7 low, high when finished or suspended.
// (RL6) host reads erase status inside a sector chosen for erasure.
// (RL7) all chosen sectors protected: polling about 100 us then array.
// (RL8) partly protected erase clears unprotected sectors without error.
// (RL9) after bit 7 turns true, host trusts full byte only next read.
// (RL10) timeout bit high: host rereads bit 7 before declaring failure.
// (RL11) ready/busy is open drain, valid after last write strobe.
// (RL12) ready/busy low while programming or erasing, high otherwise.
// (RL13) bit 6 inverts each read while operation runs, then stops.
// (RL14) bit 6 status valid after last write strobe and in erase timeout.
// (RL15) all erase sectors protected: bit 6 toggles about 100 us.
// (RL16) protected program target: bit 6 toggles about 1 us.
// (RL17) bit 6 stops in erase suspend, toggles during suspended program.
// (RL18) bit 2 toggles on reads inside erase sectors, erasing or suspended.
// (RL19) toggle check starts with two back-to-back reads compared.
// (RL20) toggling with timeout high: recheck; still toggling means fail, reset.
// (RL21) leaving toggle polling means restarting with the double read.
// (RL22) bit 5 high when operation exceeds its internal limit.
// (RL23) after timeout failure host writes reset byte f0 at any address.
// (RL24) status read is ordinary read: ce and oe low, we high.
module fwsr_poller
  import fwsr_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // register port
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // flash pins
  output fwsr_pins_t flash_o,
  input wire logic [7:0] dq_in,
  input wire logic ready_busy_n
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    fwsr_state_t st;
    fwsr_pins_t pins;
    logic [31:0] rdata;
    logic [21:0] poll_addr;
    logic [7:0] expect_byte;
    logic mode_toggle;
    logic busy;
    logic done;
    logic fail;
    logic [7:0] last;
    logic have_last;
    logic tmo_seen;
    logic true_seen;
    logic [7:0] data_byte;
    logic [7:0] cnt;
    logic [7:0] dq_s1;
    logic [7:0] dq_s2;
    logic rb_s1;
    logic rb_s2;
  } fwsr_regs_t;

  fwsr_regs_t q;
  fwsr_regs_t d;
  logic [7:0] smp;

  assign flash_o = q.pins;

  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      q <= '0;
      q.st <= ST_IDLE;
      q.pins.ce_n <= 1'b1;
      q.pins.oe_n <= 1'b1;
      q.pins.we_n <= 1'b1;
      q.rb_s1 <= 1'b1;
      q.rb_s2 <= 1'b1;
    end
    else
    begin
      q <= d;
    end
  end

  always_comb
  begin
    d = q;
    smp = q.dq_s2;
    d.dq_s1 = dq_in;
    d.dq_s2 = q.dq_s1;
    d.rb_s1 = ready_busy_n;
    d.rb_s2 = q.rb_s1;
    d.rdata = '0;
    // ----------------------------------------------------------------
    // register port
    // ----------------------------------------------------------------
    if (reg_rd)
    begin
      case (reg_addr)
        REG_ADDR: d.rdata = {10'h000, q.poll_addr};
        REG_EXPECT: d.rdata = {24'h000000, q.expect_byte};
        REG_STATUS: d.rdata = {28'h0000000, q.rb_s2, q.fail, q.done, q.busy}; // RL12
        REG_DATA: d.rdata = {24'h000000, q.data_byte};
        REG_CTRL: d.rdata = {30'h00000000, q.mode_toggle, 1'b0};
        default: d.rdata = '0;
      endcase
    end
    if (reg_wr && !q.busy)
    begin
      case (reg_addr)
        REG_ADDR: d.poll_addr = reg_wdata[21:0]; // RL3 RL6
        REG_EXPECT: d.expect_byte = reg_wdata[7:0];
        REG_CTRL:
        begin
          d.mode_toggle = reg_wdata[CTRL_MODE];
          if (reg_wdata[CTRL_RST])
          begin
            d.busy = 1'b1;
            d.done = 1'b0;
            d.fail = 1'b0;
            d.cnt = 8'h00;
            d.st = ST_WR;
          end
          else if (reg_wdata[CTRL_GO])
          begin
            // every toggle-mode start begins with a fresh double read
            d.busy = 1'b1;
            d.done = 1'b0;
            d.fail = 1'b0;
            d.have_last = 1'b0; // RL21
            d.tmo_seen = 1'b0;
            d.true_seen = 1'b0;
            d.cnt = 8'h00;
            d.st = ST_RD;
          end
        end
        default: ;
      endcase
    end
    // ----------------------------------------------------------------
    // flash sequencer
    // ----------------------------------------------------------------
    case (q.st)
      ST_IDLE: ;
      ST_RD:
      begin
        // plain read cycle, with two extra cycles for the data sampler
        d.pins.addr = q.poll_addr; // RL3
        d.pins.ce_n = 1'b0; // RL24
        d.pins.oe_n = 1'b0;
        d.pins.we_n = 1'b1;
        d.pins.dq_oe = 1'b0;
        d.cnt = q.cnt + 8'h01;
        if (q.cnt == 8'(STROBE_CYC + 2))
        begin
          d.pins.ce_n = 1'b1;
          d.pins.oe_n = 1'b1;
          d.cnt = 8'h00;
          d.st = ST_EVAL;
        end
      end
      ST_EVAL:
      begin
        d.st = ST_RD;
        d.have_last = 1'b1;
        d.last = smp;
        if (q.true_seen)
        begin
          // byte after the status went true (bit 7 matched, or bit 6 stopped toggling) is the valid one
          d.data_byte = smp; // RL9
          d.done = 1'b1;
          d.busy = 1'b0;
          d.st = ST_IDLE;
        end
        else if (!q.mode_toggle)
        begin
          if (smp[POLL_BIT] == q.expect_byte[POLL_BIT]) // RL1 RL5
            d.true_seen = 1'b1;
          else if (q.tmo_seen)
          begin
            d.fail = 1'b1; // RL10
            d.st = ST_WR;
          end
          else if (smp[TMO_BIT]) // RL22
            d.tmo_seen = 1'b1;
        end
        else if (q.have_last) // RL19
        begin
          if (smp[TOGGLE_BIT] == q.last[TOGGLE_BIT]) // RL13
            d.true_seen = 1'b1;
          else if (q.tmo_seen)
          begin
            d.fail = 1'b1; // RL20
            d.st = ST_WR;
          end
          else if (smp[TMO_BIT])
            d.tmo_seen = 1'b1;
        end
      end
      ST_WR:
      begin
        // single reset write at any address
        d.pins.addr = '0;
        d.pins.dq_out = RESET_CMD; // RL23
        d.pins.dq_oe = 1'b1;
        d.pins.ce_n = 1'b0;
        d.pins.we_n = 1'b0;
        d.pins.oe_n = 1'b1;
        d.cnt = q.cnt + 8'h01;
        if (q.cnt == 8'(STROBE_CYC - 1))
        begin
          d.pins.ce_n = 1'b1;
          d.pins.we_n = 1'b1;
          d.cnt = 8'h00;
          d.st = ST_WGAP;
        end
      end
      ST_WGAP:
      begin
        d.cnt = q.cnt + 8'h01;
        if (q.cnt == 8'(GAP_CYC - 1))
        begin
          d.pins.dq_oe = 1'b0;
          d.busy = 1'b0;
          d.done = !q.fail;
          d.cnt = 8'h00;
          d.st = ST_IDLE;
        end
      end
      default: d.st = ST_IDLE;
    endcase
  end

  assign reg_rdata = q.rdata;

endmodule

/* File: rtl/fwsr_pkg.sv */
// package for the flash write status poller
package fwsr_pkg;
  // flash status bit positions on the data bus
  localparam int POLL_BIT = 7;
  localparam int TOGGLE_BIT = 6;
  localparam int TMO_BIT = 5;
  localparam int SECT_BIT = 2;
  // reset command byte
  localparam logic [7:0] RESET_CMD = 8'hf0;
  // register offsets of the controller's own port
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_ADDR = 4'h1;
  localparam logic [3:0] REG_EXPECT = 4'h2;
  localparam logic [3:0] REG_STATUS = 4'h3;
  localparam logic [3:0] REG_DATA = 4'h4;
  // control register fields
  localparam int CTRL_GO = 0;
  localparam int CTRL_MODE = 1;
  localparam int CTRL_RST = 2;
  // status register fields
  localparam int ST_BUSY = 0;
  localparam int ST_DONE = 1;
  localparam int ST_FAIL = 2;
  localparam int ST_RDYBSY = 3;
  // bus cycle timing: strobe low time and gap, in ns
  localparam int CLK_NS = 25;
  localparam int STROBE_NS = 100;
  localparam int STROBE_CYC = (STROBE_NS + CLK_NS - 1) / CLK_NS;
  localparam int GAP_NS = 50;
  localparam int GAP_CYC = (GAP_NS + CLK_NS - 1) / CLK_NS;

  typedef enum {ST_IDLE, ST_RD, ST_EVAL, ST_WR, ST_WGAP} fwsr_state_t;

  // flash pin group
  typedef struct packed {
    logic ce_n;
    logic oe_n;
    logic we_n;
    logic [21:0] addr;
    logic [7:0] dq_out;
    logic dq_oe;
  } fwsr_pins_t;
endpackage

/* File: verification/fwsr_properties.sv */
// assertions on the poller's register port and flash pins
`timescale 1ns/1ps
module fwsr_properties import fwsr_pkg::*; (
  input wire logic core_clk, resetn, reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire fwsr_pins_t flash_o
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);
  a_read_strobes: assert property (!flash_o.oe_n |-> !flash_o.ce_n && flash_o.we_n)
    else $error("bad read strobes");
  a_read_width: assert property ($fell(flash_o.oe_n) |-> !flash_o.oe_n[*6] ##1 flash_o.oe_n)
    else $error("bad read length");
  a_read_bus_free: assert property (!flash_o.oe_n |-> !flash_o.dq_oe)
    else $error("bus driven in read");
  a_addr_hold: assert property (!flash_o.ce_n && !$fell(flash_o.ce_n) |-> $stable(flash_o.addr))
    else $error("address moved");
  a_reset_byte: assert property (!flash_o.we_n |-> flash_o.dq_oe && flash_o.dq_out == RESET_CMD)
    else $error("bad reset byte");
  a_write_width: assert property ($fell(flash_o.we_n) |-> !flash_o.we_n[*3] ##1 flash_o.we_n[*2])
    else $error("bad write length");
  a_ce_release: assert property ($rose(flash_o.oe_n) |-> flash_o.ce_n)
    else $error("chip enable held");
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("stray read data");
endmodule
bind fwsr_poller fwsr_properties i_props (.core_clk(core_clk), .resetn(resetn),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .flash_o(flash_o));

/* File: verification/fwsr_flash_model.sv */
// behavioural flash device answering status reads
`timescale 1ns/1ps
module fwsr_flash_model (
  input wire logic ce_n, oe_n, we_n, go, erase, fail,
  input wire logic [7:0] wd, arr, n,
  output logic [7:0] dq,
  output logic rb_drv
);
  int left = 0;
  logic t = 1'b0;
  logic busy = 1'b0;
  logic go_q = 1'b0;
  logic oe_q = 1'b1;
  logic we_q = 1'b1;
  // one process owns the state; edges are found against the last seen levels
  always @(go or oe_n or we_n)
  begin
    if (go === 1'b1 && go_q !== 1'b1)
    begin
      busy = 1'b1;
      left = n;
    end
    if (oe_n === 1'b1 && oe_q === 1'b0 && busy)
    begin
      t = !t;
      left = left - 1;
      // status window ends, then array reads resume
      if (left <= 0 && !fail) busy = 1'b0;
    end
    if (we_n === 1'b1 && we_q === 1'b0 && wd == 8'hf0) busy = 1'b0;
    go_q = go;
    oe_q = oe_n;
    we_q = we_n;
  end
  assign rb_drv = busy;
  // status while busy, array when idle, inverse when released
  assign dq = (ce_n || oe_n) ? ~arr : !busy ? arr
    : {erase ? 1'b0 : ~arr[7], t, fail, 2'h0, erase & t, 2'h0};
endmodule

/* File: verification/fwsr_poller_tb.sv */
// self-checking bench for the flash status poller
`timescale 1ns/1ps
module fwsr_poller_tb import fwsr_pkg::*;;
  logic core_clk = 0, resetn = 0, reg_wr = 0, reg_rd = 0, drv, go = 0, erase = 0, fail = 0;
  logic [3:0] reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0, reg_rdata, v;
  logic [7:0] dq, arr = 8'h0, n = 8'h3;
  fwsr_pins_t flash_o;
  int err_total = 0, samples_checked = 0;
  wire rb = !drv;
  fwsr_poller i_dut (.core_clk(core_clk), .resetn(resetn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .flash_o(flash_o), .dq_in(dq), .ready_busy_n(rb));
  fwsr_flash_model i_flash (.ce_n(flash_o.ce_n), .oe_n(flash_o.oe_n), .we_n(flash_o.we_n),
    .go(go), .erase(erase), .fail(fail), .wd(flash_o.dq_out), .arr(arr), .n(n), .dq(dq),
    .rb_drv(drv));
  initial forever #12.5 core_clk = !core_clk;
  // every status read must carry the programmed or erased address
  always @(negedge flash_o.oe_n)
  begin
    samples_checked++;
    if (flash_o.addr !== 22'h12345)
    begin
      err_total++;
      $display("unexpected %0t status read at wrong address", $time);
    end
  end
  task print_verdict;
    $display("checks %0d errors %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_wr <= 1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 0;
  endtask
  task rd(input logic [3:0] a);
    @(posedge core_clk);
    reg_rd <= 1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 0;
    #1 v = reg_rdata;
  endtask
  task chk(input logic [31:0] e);
    samples_checked++;
    if (v !== e)
    begin
      err_total++;
      $display("unexpected %0t got %h want %h", $time, v, e);
    end
  endtask
  task wt;
    for (int i = 0; i < 300; i++)
    begin
      rd(REG_STATUS);
      if (v[ST_BUSY] === 1'b0) return;
    end
    err_total++;
    $display("unexpected %0t poller hangs", $time);
    print_verdict;
  endtask
  task run(input logic [7:0] a, input logic e, f, input logic [7:0] x, input logic [31:0] c);
    arr = a;
    erase = e;
    fail = f;
    go <= 1;
    wr(REG_ADDR, 32'h12345);
    wr(REG_EXPECT, {24'h0, x});
    wr(REG_CTRL, c);
    go <= 0;
    rd(REG_STATUS);
    chk(32'h1);
    wt;
    rd(REG_STATUS);
  endtask
  task t_reset_cmd;
    wr(REG_CTRL, 32'h4);
    wt;
    rd(REG_STATUS);
    chk(32'ha);
    rd(4'hf);
    chk(32'h0);
  endtask
  task t_prog_poll;
    run(8'h5a, 0, 0, 8'h5a, 32'h1);
    chk(32'ha);
    rd(REG_DATA);
    chk(32'h5a);
  endtask
  task t_erase_toggle;
    n = 8'h4;
    run(8'hff, 1, 0, 8'h80, 32'h3);
    chk(32'ha);
    rd(REG_DATA);
    chk(32'hff);
    rd(REG_CTRL);
    chk(32'h2);
  endtask
  task t_fail;
    run(8'h00, 0, 1, 8'h00, 32'h1);
    fail = 0;
    chk(32'hc);
  endtask
  task t_erase_poll;
    run(8'hff, 1, 0, 8'h80, 32'h1);
    chk(32'ha);
    rd(REG_DATA);
    chk(32'hff);
  endtask
  task t_fail_toggle;
    run(8'h00, 0, 1, 8'h00, 32'h3);
    fail = 0;
    chk(32'hc);
  endtask
  initial
  begin
    repeat (5) @(posedge core_clk);
    resetn <= 1;
    rd(REG_STATUS);
    chk(32'h8);
    t_reset_cmd;
    t_prog_poll;
    t_erase_toggle;
    t_fail;
    t_erase_poll;
    t_fail_toggle;
    print_verdict;
  end
endmodule
